// [src/err_rec_pkg.sv]
// Package for the error record update block: field layouts, offsets, codes.
// Assumes a single 25 MHz clock and a plain register port.
package err_rec_pkg;

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_ADDR   = 8'h04;
	localparam logic [7:0] OFF_MISC0  = 8'h08;
	localparam logic [7:0] OFF_STAMP  = 8'h0C;
	localparam logic [7:0] OFF_CTRL   = 8'h10;
	localparam logic [7:0] OFF_CFG    = 8'h14;

	// Status bit positions
	localparam int ST_VALID = 31;
	localparam int ST_ADDRV = 30;
	localparam int ST_UNC   = 29;
	localparam int ST_OVF   = 27;
	localparam int ST_MISCV = 26;
	localparam int ST_CORR  = 24;
	localparam int ST_POST  = 23;
	localparam int ST_POIS  = 22;
	localparam int ST_UET   = 20;
	localparam int ST_ABRT  = 19;
	localparam int ST_IMPL  = 8;
	localparam int ST_SRC   = 0;

	// Control bit positions
	localparam int CT_PRI   = 0;
	localparam int CT_URI   = 1;
	localparam int CT_FI    = 2;
	localparam int CT_CFI   = 3;
	localparam int CT_RAB   = 4;
	localparam int CT_WAB   = 5;

	// Config bit positions (lowest-numbered security bit)
	localparam int CF_NS_OK = 0;

	localparam logic [1:0] CORR_ONE  = 2'h1;
	localparam logic [1:0] CORR_MANY = 2'h2;
	localparam logic [31:0] ZERO32   = 32'h0000_0000;
	localparam logic [7:0]  CNT_MAX  = 8'hFF;

	// Error types, ordered by priority
	typedef enum logic [2:0] {
		ET_NONE  = 3'h0,
		ET_CORR  = 3'h1,
		ET_POST  = 3'h2,
		ET_RST   = 3'h3,
		ET_REC   = 3'h4,
		ET_UNREC = 3'h5,
		ET_UNCON = 3'h6
	} err_type_t;

	// New-error report from the detector
	typedef struct packed {
		logic       valid;
		err_type_t  etype;
		logic       is_write;
		logic       poison;
		logic [7:0] impl_code;
		logic [7:0] src_code;
		logic       has_addr;
		logic [31:0] addr;
		logic       has_misc;
		logic [31:0] misc;
	} err_report_t;

	// Interrupt and abort outputs
	typedef struct packed {
		logic recovery_irq;
		logic fault_irq;
		logic abort;
	} err_sig_t;

endpackage : err_rec_pkg

// [src/type_reduce.sv]
// Maps a detected error type onto the reduced set this node records.
// Assumes combinational use inside the record block.
`timescale 1ns/100ps
`default_nettype none
module type_reduce
	import err_rec_pkg::*;
#(
	parameter bit HAS_RST = 1'b0,
	parameter bit HAS_REC = 1'b1
) (
	input  wire err_type_t in_i,
	output var  err_type_t out_o
);
	// Promote unsupported uncorrected types upward
	always_comb begin
		out_o = in_i;
		if (in_i == ET_RST && !HAS_RST)
			out_o = HAS_REC ? ET_REC : ET_UNREC;
		else if (in_i == ET_REC && !HAS_REC)
			out_o = ET_UNREC;
	end
endmodule : type_reduce
`default_nettype wire

// [src/corr_counter.sv]
// Corrected error counter that flags each unsigned wrap as an event.
// Assumes increments arrive as single-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module corr_counter
	import err_rec_pkg::*;
(
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       inc_i,
	output var  logic [7:0] count_o,
	output var  logic       wrap_o
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       wrap;
	} cc_state_t;

	cc_state_t st_r;
	cc_state_t st_nxt;

	// Count and mark overflow
	always_comb begin
		st_nxt      = st_r;
		st_nxt.wrap = 1'b0;
		if (inc_i) begin
			st_nxt.cnt  = st_r.cnt + 8'h01;
			st_nxt.wrap = (st_r.cnt == CNT_MAX);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign count_o = st_r.cnt;
	assign wrap_o  = st_r.wrap;
endmodule : corr_counter
`default_nettype wire

// [src/err_record.sv]
// Error record update logic with interrupt and abort gating.
// Assumes synchronous inputs, one clock, plain register port.
//
// Summary of operation
// - Overwrite loads new syndrome, sets record valid
// - Overwrite sets or clears address valid
// - Overwrite stores timestamp, sets misc valid
// - Overwrite with misc syndrome sets misc valid
// - No new misc: keep or clear misc valid
// - Not-applicable status bits stay unchanged
// - Keep: poison, codes, address stay unchanged
// - Keep: no timestamp for discarded error
// - Keep: misc write sets misc valid
// - Type indicator updated even when discarded
// - Uncorrected types may be recorded as higher
// - Non-secure reads see no secure data
// - Non-secure cannot aim messages at secure
// - Reads after exception return updated values
// - Postponed recovery interrupt gated or never
// - Unfixed recovery interrupt gated or always
// - Fixed fault enable plus fault enable
// - Single fault enable gates all, else always
// - Counter wrap or each fixed is event
// - Fault interrupt on every non-corrected error
// - Abort enable gates uncorrected aborts
// - Signalled abort sets abort flag
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module err_record
	import err_rec_pkg::*;
#(
	parameter bit HAS_STAMP   = 1'b1,
	parameter bit HAS_COUNTER = 1'b1,
	parameter bit HAS_PRI_EN  = 1'b1,
	parameter bit HAS_URI_EN  = 1'b1,
	parameter bit HAS_CFI_EN  = 1'b1,
	parameter bit HAS_FI_EN   = 1'b1,
	parameter bit HAS_ABORT   = 1'b1,
	parameter bit SPLIT_ABORT = 1'b1,
	parameter bit MISC_ON_KEEP = 1'b1,
	parameter bit MISC_TAGGED = 1'b0
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire err_report_t report_i,
	input  wire logic        abort_req_i,
	input  wire logic        secure_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output var  logic [31:0] rdata_o,
	output var  err_sig_t    sig_o
);
	typedef struct packed {
		logic [31:0] status;
		logic [31:0] addr;
		logic [31:0] misc;
		logic [31:0] stamp;
		logic [5:0]  ctrl;
		logic        ns_ok;
		logic [31:0] time_cnt;
		err_type_t   rec_type;
		logic [31:0] rdata;
		err_sig_t    sig;
	} rec_state_t;

	rec_state_t st_r;
	rec_state_t st_nxt;
	err_type_t  new_type;
	logic       wrap;
	logic       corr_inc;

	type_reduce u_reduce (
		.in_i  (report_i.etype),
		.out_o (new_type)
	);

	assign corr_inc = report_i.valid && new_type == ET_CORR;

	corr_counter u_cnt (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.inc_i      (corr_inc),
		.count_o    (),
		.wrap_o     (wrap)
	);

	// Record update, enables and register port
	always_comb begin
		logic overwrite;
		logic is_unc;
		logic corr_evt;
		logic pri_en;
		logic uri_en;
		logic cfi_en;
		logic fi_en;
		logic ab_en;
		logic do_abort;
		overwrite = 1'b0;
		is_unc    = 1'b0;
		corr_evt  = 1'b0;
		do_abort  = 1'b0;
		st_nxt    = st_r;
		st_nxt.time_cnt = st_r.time_cnt + 32'h1;
		st_nxt.sig = '0;
		pri_en = HAS_PRI_EN ? st_r.ctrl[CT_PRI] : 1'b0;
		uri_en = HAS_URI_EN ? st_r.ctrl[CT_URI] : 1'b1;
		fi_en  = HAS_FI_EN  ? st_r.ctrl[CT_FI]  : 1'b1;
		cfi_en = HAS_CFI_EN ? st_r.ctrl[CT_CFI] : fi_en;
		ab_en  = report_i.is_write ? st_r.ctrl[CT_WAB] : st_r.ctrl[CT_RAB];
		if (!SPLIT_ABORT)
			ab_en = st_r.ctrl[CT_RAB];
		// Software writes first; a same-cycle error then wins
		if (wr_i && (secure_i || st_r.ns_ok)) begin
			case (addr_i)
				OFF_STATUS: st_nxt.status = st_r.status & ~wdata_i;
				OFF_CTRL:   st_nxt.ctrl   = wdata_i[5:0];
				OFF_CFG:    if (secure_i) st_nxt.ns_ok = wdata_i[CF_NS_OK];
				default:    ;
			endcase
			if (addr_i == OFF_STATUS && wdata_i[ST_VALID])
				st_nxt.rec_type = ET_NONE;
		end
		if (report_i.valid) begin
			is_unc = new_type >= ET_RST;
			overwrite = (new_type > st_r.rec_type) ||
				(st_r.rec_type == ET_NONE) || !st_nxt.status[ST_VALID];
			if (st_nxt.status[ST_VALID] && new_type != ET_CORR && st_r.rec_type != ET_NONE)
				st_nxt.status[ST_OVF] = 1'b1;
			do_abort = HAS_ABORT && is_unc && abort_req_i && ab_en;
			if (overwrite) begin
				st_nxt.rec_type = new_type;
				st_nxt.status[ST_VALID] = 1'b1;
				st_nxt.status[ST_POIS] = report_i.poison;
				st_nxt.status[ST_IMPL +: 8] = report_i.impl_code;
				st_nxt.status[ST_SRC +: 8] = report_i.src_code;
				st_nxt.status[ST_ABRT] = do_abort;
				if (is_unc) // Subtype only applies to uncorrected
					st_nxt.status[ST_UET +: 2] = 2'(new_type - ET_RST);
				st_nxt.status[ST_ADDRV] = report_i.has_addr;
				if (report_i.has_addr)
					st_nxt.addr = report_i.addr;
				if (report_i.has_misc) begin
					st_nxt.misc = report_i.misc;
					st_nxt.status[ST_MISCV] = 1'b1;
				end else if (!MISC_TAGGED)
					st_nxt.status[ST_MISCV] = 1'b0;
				if (HAS_STAMP) begin
					st_nxt.stamp = st_r.time_cnt;
					st_nxt.status[ST_MISCV] = 1'b1;
				end
			end else if (MISC_ON_KEEP && report_i.has_misc) begin
				st_nxt.misc = report_i.misc;
				st_nxt.status[ST_MISCV] = 1'b1;
			end
			if (do_abort)
				st_nxt.status[ST_ABRT] = 1'b1;
			// Type indicator, even on discard
			case (new_type)
				ET_CORR: if (st_nxt.status[ST_CORR +: 2] == 2'h0)
					st_nxt.status[ST_CORR +: 2] = CORR_ONE;
				else
					st_nxt.status[ST_CORR +: 2] = CORR_MANY;
				ET_POST: st_nxt.status[ST_POST] = 1'b1;
				default: st_nxt.status[ST_UNC] = 1'b1;
			endcase
			corr_evt = HAS_COUNTER ? 1'b0 : (new_type == ET_CORR);
			st_nxt.sig.recovery_irq = (new_type == ET_POST && pri_en) || (is_unc && uri_en);
			st_nxt.sig.fault_irq = (new_type != ET_CORR && fi_en) || (corr_evt && cfi_en);
			st_nxt.sig.abort = do_abort;
		end
		// Counter wrap always flags overflow; only the interrupt is gated
		if (HAS_COUNTER && wrap) begin
			st_nxt.status[ST_OVF] = 1'b1;
			if (cfi_en)
				st_nxt.sig.fault_irq = 1'b1;
		end
		// Reads return the registered record, never older than a pulse
		st_nxt.rdata = ZERO32;
		if (rd_i && (secure_i || st_r.ns_ok)) begin
			case (addr_i)
				OFF_STATUS: st_nxt.rdata = st_r.status;
				OFF_ADDR:   st_nxt.rdata = st_r.addr;
				OFF_MISC0:  st_nxt.rdata = st_r.misc;
				OFF_STAMP:  st_nxt.rdata = st_r.stamp;
				OFF_CTRL:   st_nxt.rdata = {26'h0, st_r.ctrl};
				OFF_CFG:    st_nxt.rdata = {31'h0, st_r.ns_ok};
				default:    st_nxt.rdata = ZERO32;
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign rdata_o = st_r.rdata;
	assign sig_o   = st_r.sig;

	// Checks
	a_valid_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		report_i.valid |=> st_r.status[ST_VALID]) else $error("record valid not set");
	a_abort_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		sig_o.abort |-> st_r.status[ST_ABRT]) else $error("abort flag missing");
	a_fault_all: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(report_i.valid && report_i.etype >= ET_POST && st_r.ctrl[CT_FI]) |=> sig_o.fault_irq)
		else $error("fault irq missing");
	a_post_type: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(report_i.valid && report_i.etype == ET_POST) |=> st_r.status[ST_POST])
		else $error("postponed flag missing");
	a_keep_addr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(report_i.valid && !wr_i && st_r.status[ST_VALID] && report_i.etype <= st_r.rec_type)
		|=> st_r.addr == $past(st_r.addr)) else $error("address changed on keep");
	a_addr_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(report_i.valid && !report_i.has_addr && !st_r.status[ST_VALID])
		|=> !st_r.status[ST_ADDRV]) else $error("address valid not cleared");
	a_post_irq: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(report_i.valid && report_i.etype == ET_POST && !st_r.ctrl[CT_PRI]) |=> !sig_o.recovery_irq)
		else $error("postponed irq not gated");
	a_unc_irq: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(report_i.valid && report_i.etype >= ET_RST && st_r.ctrl[CT_URI]) |=> sig_o.recovery_irq)
		else $error("unfixed irq missing");
	a_stamp_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(report_i.valid && !wr_i && st_r.status[ST_VALID] && report_i.etype <= st_r.rec_type)
		|=> st_r.stamp == $past(st_r.stamp)) else $error("timestamp taken on keep");
	a_stamp_misc: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(HAS_STAMP && report_i.valid && !st_r.status[ST_VALID]) |=> st_r.status[ST_MISCV])
		else $error("misc valid not set with timestamp");
	a_misc_keep: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(MISC_ON_KEEP && report_i.valid && report_i.has_misc) |=> st_r.status[ST_MISCV])
		else $error("misc valid not set with misc");
	a_corr_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(HAS_COUNTER && report_i.valid && report_i.etype == ET_CORR && !wrap) |=> !sig_o.fault_irq)
		else $error("fault irq without counter wrap");
	a_abort_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		(HAS_ABORT && report_i.valid && report_i.etype >= ET_RST && abort_req_i && !report_i.is_write
		&& st_r.ctrl[CT_RAB]) |=> sig_o.abort) else $error("read abort not signalled");
	c_corr_wrap: cover property (@(posedge core_clk_i) wrap && st_r.ctrl[CT_CFI]);
	c_overwrite: cover property (@(posedge core_clk_i) report_i.valid && !st_r.status[ST_VALID]);
	c_keep: cover property (@(posedge core_clk_i) report_i.valid && st_r.rec_type == ET_UNCON);
	c_abort: cover property (@(posedge core_clk_i) sig_o.abort);
endmodule : err_record
`default_nettype wire

// [test/err_host_model.sv]
// Far-side model: interrupt controller that tallies the pulses of the error node.
// Assumes sig_i holds registered one-cycle pulses on core_clk_i.
`timescale 1ns/100ps
`default_nettype none
module err_host_model
	import err_rec_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire err_sig_t    sig_i,
	output var  logic [15:0] fault_cnt_o,
	output var  logic [15:0] recov_cnt_o,
	output var  logic [15:0] abort_cnt_o
);
	// Count each pulse once; a level would count every cycle
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			fault_cnt_o <= 16'h0000;
			recov_cnt_o <= 16'h0000;
			abort_cnt_o <= 16'h0000;
		end else begin
			fault_cnt_o <= fault_cnt_o + 16'(sig_i.fault_irq);
			recov_cnt_o <= recov_cnt_o + 16'(sig_i.recovery_irq);
			abort_cnt_o <= abort_cnt_o + 16'(sig_i.abort);
		end
	end
endmodule : err_host_model
`default_nettype wire

// [test/err_record_test.sv]
// Testbench for the error record block: register tasks and error reports.
// Assumes the package constants and the host model beside it.
`timescale 1ns/100ps
`default_nettype none
module err_record_test;
	import err_rec_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        rst_n_i    = 1'b0;
	err_report_t rep        = '0;
	logic        abort_req  = 1'b0;
	logic        secure     = 1'b0;
	logic [7:0]  addr       = 8'h00;
	logic [31:0] wdata      = 32'h0000_0000;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic [31:0] rdata;
	err_sig_t    sig;
	logic [15:0] fault_cnt, recov_cnt, abort_cnt;
	logic [31:0] v, s0;
	logic [15:0] f0;
	int          failures = 0;
	int          checked  = 0;

	always #20 core_clk_i = ~core_clk_i;

	err_record dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .report_i(rep), .abort_req_i(abort_req),
		.secure_i(secure), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sig_o(sig));
	err_host_model host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sig_i(sig),
		.fault_cnt_o(fault_cnt), .recov_cnt_o(recov_cnt), .abort_cnt_o(abort_cnt));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic finish_test;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test

	// Register write: one strobe cycle
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge core_clk_i);
		wr <= 1'b0;
	endtask : reg_wr

	// Register read: data stands in the cycle after the strobe
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		rd <= 1'b1; addr <= a;
		@(posedge core_clk_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : reg_rd

	// One-cycle error report; sig_o is settled just after the taking edge
	task automatic send(input err_type_t et, input logic w, input logic ab, input logic ha, input logic hm,
		input logic [7:0] code);
		@(posedge core_clk_i);
		rep <= '{valid: 1'b1, etype: et, is_write: w, poison: code[0], impl_code: code, src_code: ~code,
			has_addr: ha, addr: {24'h123456, code}, has_misc: hm, misc: {code, 24'hC0FFEE}};
		abort_req <= ab;
		@(posedge core_clk_i);
		rep.valid <= 1'b0;
		#1;
	endtask : send

	initial begin
		#2000000;
		failures++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		secure  <= 1'b1;
		reg_wr(OFF_CTRL, 32'h0000_003F);
		// Overwrite into an empty record, everything enabled
		send(ET_UNCON, 1'b0, 1'b1, 1'b1, 1'b1, 8'h5B);
		chk("sig uncon", {29'h0, sig}, 32'h0000_0007);
		reg_rd(OFF_STATUS, v);
		chk("status overwrite", v & 32'hF7CF_FFFF, 32'hE448_5BA4);
		reg_rd(OFF_ADDR, v);
		chk("addr overwrite", v, 32'h1234_565B);
		reg_rd(OFF_MISC0, v);
		chk("misc overwrite", v, 32'h5BC0_FFEE);
		reg_rd(OFF_STAMP, s0);
		// Lower-priority error is kept behind the record
		send(ET_POST, 1'b0, 1'b0, 1'b1, 1'b1, 8'h22);
		chk("sig keep", {29'h0, sig}, 32'h0000_0006);
		reg_rd(OFF_STATUS, v);
		chk("status keep", v & 32'hF7CF_FFFF, 32'hE4C8_5BA4);
		reg_rd(OFF_ADDR, v);
		chk("addr keep", v, 32'h1234_565B);
		reg_rd(OFF_STAMP, v);
		chk("stamp keep", v, s0);
		reg_rd(OFF_MISC0, v);
		chk("misc keep", v, 32'h22C0_FFEE);
		// Split abort enables: read abort only
		reg_wr(OFF_CTRL, 32'h0000_0010);
		send(ET_UNCON, 1'b1, 1'b1, 1'b0, 1'b0, 8'h33);
		chk("sig write abort off", {29'h0, sig}, 32'h0000_0000);
		send(ET_UNCON, 1'b0, 1'b1, 1'b0, 1'b0, 8'h34);
		chk("sig read abort on", {29'h0, sig}, 32'h0000_0001);
		// Fresh record, postponed error without address or misc
		reg_wr(OFF_STATUS, 32'hFFFF_FFFF);
		reg_wr(OFF_CTRL, 32'h0000_0001);
		send(ET_POST, 1'b0, 1'b0, 1'b0, 1'b0, 8'h44);
		chk("sig post recovery", {29'h0, sig}, 32'h0000_0004);
		reg_rd(OFF_STATUS, v);
		chk("status post", v & 32'hC480_0000, 32'h8480_0000);
		reg_wr(OFF_CTRL, 32'h0000_0004);
		send(ET_POST, 1'b0, 1'b0, 1'b0, 1'b0, 8'h45);
		chk("sig post fault", {29'h0, sig}, 32'h0000_0002);
		// Corrected errors: fault only on counter wrap, and only with the fixed enable
		for (int i = 0; i < 2; i++) begin
			reg_wr(OFF_CTRL, (i == 1) ? 32'h0000_0008 : 32'h0000_0004);
			f0 = fault_cnt;
			repeat (256) send(ET_CORR, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01);
			repeat (3) @(posedge core_clk_i);
			chk("corrected wrap faults", {16'h0, fault_cnt - f0}, 32'(i));
		end
		// Non-secure access sees nothing and changes nothing
		secure <= 1'b0;
		reg_rd(OFF_CTRL, v);
		chk("nonsecure read", v, 32'h0000_0000);
		reg_wr(OFF_CTRL, 32'h0000_003F);
		secure <= 1'b1;
		reg_rd(OFF_CTRL, v);
		chk("nonsecure write", v & 32'h0000_003F, 32'h0000_0008);
		// Secure side opens the record to non-secure reads
		reg_wr(OFF_CFG, 32'h0000_0001);
		secure <= 1'b0;
		reg_rd(OFF_CTRL, v);
		chk("nonsecure visible", v, 32'h0000_0008);
		reg_wr(OFF_CFG, 32'h0000_0000);
		reg_rd(OFF_CFG, v);
		chk("nonsecure cfg write", v, 32'h0000_0001);
		secure <= 1'b1;
		reg_rd(8'h1C, v);
		chk("unmapped read", v, 32'h0000_0000);
		// Pulse totals seen by the far side over the whole run
		chk("fault pulses", {16'h0, fault_cnt}, 32'h0000_0004);
		chk("recovery pulses", {16'h0, recov_cnt}, 32'h0000_0003);
		chk("abort pulses", {16'h0, abort_cnt}, 32'h0000_0002);
		finish_test();
	end
endmodule : err_record_test
`default_nettype wire
